// ===== esx_defs.svh
// Constants for the extended skip, table read and XOR execution block
`ifndef ESX_DEFS_SVH
`define ESX_DEFS_SVH

`define ESX_BYTE_W       8
`define ESX_WORD_W       16
`define ESX_PAGE_W       4
`define ESX_ZERO_BYTE    8'h00
`define ESX_RESET_BYTE   8'h00
`define ESX_RESET_PAGE   4'h0
`define ESX_PTR_STEP     8'h01
`define ESX_LOW_LSB      0
`define ESX_HIGH_LSB     8
`define ESX_SKIP_CYCLES  2

`endif

// ===== esx_pkg.sv
// Types for the extended skip, table read and XOR execution block
package esx_pkg;

  typedef enum logic [3:0] {
    ESX_OP_NONE,
    ESX_OP_SKIP_ZERO_MOVE_TO_ACC,
    ESX_OP_SKIP_BIT_ZERO,
    ESX_OP_TABLE_READ_CURRENT_PAGE,
    ESX_OP_TABLE_READ_LAST_PAGE,
    ESX_OP_PREINC_TABLE_READ,
    ESX_OP_PREINC_TABLE_READ_LAST_PAGE,
    ESX_OP_XOR_TO_ACCUMULATOR,
    ESX_OP_XOR_TO_MEMORY
  } esx_op_t;

  typedef enum logic [1:0] {
    ESX_ST_IDLE,
    ESX_ST_SKIP_DUMMY,
    ESX_ST_TABLE_WAIT
  } esx_state_t;

endpackage : esx_pkg

// ===== esx_exec.sv
// Execution unit for extended skip, table read and XOR instructions
// What this block does
// RL1: Zero-move skip copies byte to accumulator, skips zero
// RL2: Taken skip inserts dummy cycle, two cycles total
// RL3: False skip condition continues with next instruction
// RL4: Bit-test skip skips when selected bit is zero
// RL5: Current-page read splits word to memory, latch
// RL6: Last-page read splits word to memory, latch
// RL7: Incrementing read bumps low pointer, uses both pointers
// RL8: Incrementing last-page read bumps pointer, reads last page
// RL9: XOR to accumulator, only zero flag changes
// RL10: XOR to memory, only zero flag changes
// RL11: Zero flag from XOR result; others keep flags
`timescale 1ns/100ps
`default_nettype none
`include "esx_defs.svh"

module esx_exec
  import esx_pkg::*;
#(
  parameter int BYTE_W = `ESX_BYTE_W,
  parameter int WORD_W = `ESX_WORD_W,
  parameter int PAGE_W = `ESX_PAGE_W
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic              i_op_valid,
  input  wire esx_op_t           i_op_code,
  input  wire logic [2:0]        i_bit_sel,
  input  wire logic [BYTE_W-1:0] i_mem_rdata,
  input  wire logic [PAGE_W-1:0] i_pc_page,
  input  wire logic              i_ptr_low_we,
  input  wire logic [BYTE_W-1:0] i_ptr_low_wdata,
  input  wire logic              i_ptr_high_we,
  input  wire logic [PAGE_W-1:0] i_ptr_high_wdata,
  input  wire logic              i_acc_we,
  input  wire logic [BYTE_W-1:0] i_acc_wdata,
  input  wire logic [WORD_W-1:0] i_pm_rdata,
  output logic                   o_busy,
  output logic                   o_dummy,
  output logic                   o_skip,
  output logic                   o_pm_rd,
  output logic [PAGE_W+BYTE_W-1:0] o_pm_addr,
  output logic                   o_mem_we,
  output logic [BYTE_W-1:0]      o_mem_wdata,
  output logic [BYTE_W-1:0]      o_accumulator,
  output logic                   o_zero_flag,
  output logic [BYTE_W-1:0]      o_table_pointer_low,
  output logic [PAGE_W-1:0]      o_table_pointer_high,
  output logic [BYTE_W-1:0]      o_table_high_byte_latch
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_table_op(input esx_op_t op);
    is_table_op = (op == ESX_OP_TABLE_READ_CURRENT_PAGE) ||
                  (op == ESX_OP_TABLE_READ_LAST_PAGE) ||
                  (op == ESX_OP_PREINC_TABLE_READ) ||
                  (op == ESX_OP_PREINC_TABLE_READ_LAST_PAGE);
  endfunction : is_table_op

  function automatic logic is_preinc_op(input esx_op_t op);
    is_preinc_op = (op == ESX_OP_PREINC_TABLE_READ) ||
                   (op == ESX_OP_PREINC_TABLE_READ_LAST_PAGE);
  endfunction : is_preinc_op

  function automatic logic is_last_page_op(input esx_op_t op);
    is_last_page_op = (op == ESX_OP_TABLE_READ_LAST_PAGE) ||
                      (op == ESX_OP_PREINC_TABLE_READ_LAST_PAGE);
  endfunction : is_last_page_op

  // ****************************************
  // Issue and combinational results
  // ****************************************
  esx_state_t        state_reg;
  logic              issue;
  logic              skip_cond;
  logic [BYTE_W-1:0] xor_result;
  logic [BYTE_W-1:0] ptr_low_next;
  logic [PAGE_W-1:0] page_sel;

  assign o_busy     = (state_reg != ESX_ST_IDLE);
  assign o_dummy    = (state_reg == ESX_ST_SKIP_DUMMY);
  assign issue      = i_op_valid && !o_busy;
  assign xor_result = o_accumulator ^ i_mem_rdata;

  always_comb begin
    skip_cond = 1'b0;
    case (i_op_code)
      ESX_OP_SKIP_ZERO_MOVE_TO_ACC: begin
        skip_cond = (i_mem_rdata == `ESX_ZERO_BYTE); // see RL1
      end
      ESX_OP_SKIP_BIT_ZERO: begin
        skip_cond = !i_mem_rdata[i_bit_sel]; // see RL4
      end
      default: begin
        skip_cond = 1'b0;
      end
    endcase
  end

  // Pre-increment feeds the address in the same issue cycle
  assign ptr_low_next = is_preinc_op(i_op_code) ?
                        o_table_pointer_low + `ESX_PTR_STEP :
                        o_table_pointer_low; // see RL7 see RL8

  always_comb begin
    if (is_last_page_op(i_op_code)) begin
      page_sel = '1; // see RL6 see RL8
    end else if (i_op_code == ESX_OP_PREINC_TABLE_READ) begin
      page_sel = o_table_pointer_high; // see RL7
    end else begin
      page_sel = i_pc_page; // see RL5
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_reg <= ESX_ST_IDLE;
    end else begin
      case (state_reg)
        ESX_ST_IDLE: begin
          if (issue && skip_cond) begin
            state_reg <= ESX_ST_SKIP_DUMMY; // see RL2
          end else if (issue && is_table_op(i_op_code)) begin
            state_reg <= ESX_ST_TABLE_WAIT;
          end
        end
        ESX_ST_SKIP_DUMMY: begin
          state_reg <= ESX_ST_IDLE;
        end
        ESX_ST_TABLE_WAIT: begin
          state_reg <= ESX_ST_IDLE;
        end
        default: begin
          state_reg <= ESX_ST_IDLE;
        end
      endcase
    end
  end

  // Skip pulse marks the instruction to be discarded
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_skip <= 1'b0;
    end else begin
      o_skip <= issue && skip_cond; // see RL2 see RL3
    end
  end

  // ****************************************
  // Program memory access
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pm_rd   <= 1'b0;
      o_pm_addr <= '0;
    end else begin
      o_pm_rd <= issue && is_table_op(i_op_code);
      if (issue && is_table_op(i_op_code)) begin
        o_pm_addr <= {page_sel, ptr_low_next}; // see RL5 see RL6
      end
    end
  end

  // ****************************************
  // Table pointers and high byte latch
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_table_pointer_low <= `ESX_RESET_BYTE;
    end else if (issue && is_preinc_op(i_op_code)) begin
      o_table_pointer_low <= ptr_low_next; // see RL7 see RL8
    end else if (i_ptr_low_we) begin
      o_table_pointer_low <= i_ptr_low_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_table_pointer_high <= `ESX_RESET_PAGE;
    end else if (i_ptr_high_we) begin
      o_table_pointer_high <= i_ptr_high_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_table_high_byte_latch <= `ESX_RESET_BYTE;
    end else if (state_reg == ESX_ST_TABLE_WAIT) begin
      o_table_high_byte_latch <= i_pm_rdata[`ESX_HIGH_LSB +: BYTE_W]; // see RL5 see RL6
    end
  end

  // ****************************************
  // Data memory write port
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= `ESX_RESET_BYTE;
    end else if (state_reg == ESX_ST_TABLE_WAIT) begin
      o_mem_we    <= 1'b1;
      o_mem_wdata <= i_pm_rdata[`ESX_LOW_LSB +: BYTE_W]; // see RL7 see RL8
    end else if (issue && i_op_code == ESX_OP_XOR_TO_MEMORY) begin
      o_mem_we    <= 1'b1;
      o_mem_wdata <= xor_result; // see RL10
    end else begin
      o_mem_we    <= 1'b0;
    end
  end

  // ****************************************
  // Accumulator and zero flag
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_accumulator <= `ESX_RESET_BYTE;
    end else if (issue && i_op_code == ESX_OP_SKIP_ZERO_MOVE_TO_ACC) begin
      o_accumulator <= i_mem_rdata; // see RL1
    end else if (issue && i_op_code == ESX_OP_XOR_TO_ACCUMULATOR) begin
      o_accumulator <= xor_result; // see RL9
    end else if (i_acc_we) begin
      o_accumulator <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_zero_flag <= 1'b0;
    end else if (issue && (i_op_code == ESX_OP_XOR_TO_ACCUMULATOR ||
                           i_op_code == ESX_OP_XOR_TO_MEMORY)) begin
      o_zero_flag <= (xor_result == `ESX_ZERO_BYTE); // see RL11
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  zero_move_skip_a: assert property ( // see RL1
    issue && i_op_code == ESX_OP_SKIP_ZERO_MOVE_TO_ACC |=>
      o_accumulator == $past(i_mem_rdata) && o_skip == ($past(i_mem_rdata) == 8'h00))
    else $error("zero move skip wrong");

  skip_two_cycle_a: assert property ( // see RL2
    o_skip |-> o_dummy ##1 !o_busy)
    else $error("skip not two cycles");

  no_false_skip_a: assert property ( // see RL3
    issue && !skip_cond && !is_table_op(i_op_code) |=> !o_skip && !o_busy)
    else $error("skip without cause");

  bit_skip_a: assert property ( // see RL4
    issue && i_op_code == ESX_OP_SKIP_BIT_ZERO |=>
      o_skip == !$past(i_mem_rdata[i_bit_sel]))
    else $error("bit skip wrong");

  table_page_a: assert property ( // see RL5
    issue && i_op_code == ESX_OP_TABLE_READ_CURRENT_PAGE |=>
      o_pm_rd && o_pm_addr == {$past(i_pc_page), $past(o_table_pointer_low)})
    else $error("current page address wrong");

  last_page_a: assert property ( // see RL6
    issue && is_last_page_op(i_op_code) |=> o_pm_rd && o_pm_addr[PAGE_W+BYTE_W-1 -: PAGE_W] == '1)
    else $error("last page address wrong");

  table_split_a: assert property ( // see RL7
    o_pm_rd |=> o_mem_we && o_mem_wdata == $past(i_pm_rdata[7:0]) &&
      o_table_high_byte_latch == $past(i_pm_rdata[15:8]))
    else $error("table bytes misplaced");

  preinc_ptr_a: assert property ( // see RL8
    issue && is_preinc_op(i_op_code) |=>
      o_table_pointer_low == $past(o_table_pointer_low) + 8'h01 &&
      o_pm_addr[BYTE_W-1:0] == o_table_pointer_low)
    else $error("pre increment wrong");

  xor_acc_a: assert property ( // see RL9
    issue && i_op_code == ESX_OP_XOR_TO_ACCUMULATOR |=>
      o_accumulator == ($past(o_accumulator) ^ $past(i_mem_rdata)) && !o_mem_we)
    else $error("xor to accumulator wrong");

  xor_mem_a: assert property ( // see RL10
    issue && i_op_code == ESX_OP_XOR_TO_MEMORY |=>
      o_mem_we && o_mem_wdata == ($past(o_accumulator) ^ $past(i_mem_rdata)) &&
      $stable(o_accumulator))
    else $error("xor to memory wrong");

  zero_flag_a: assert property ( // see RL11
    issue && (i_op_code == ESX_OP_XOR_TO_ACCUMULATOR || i_op_code == ESX_OP_XOR_TO_MEMORY)
      |=> o_zero_flag == ($past(o_accumulator ^ i_mem_rdata) == 8'h00))
    else $error("zero flag wrong");

  flag_hold_a: assert property ( // see RL11
    !(issue && (i_op_code == ESX_OP_XOR_TO_ACCUMULATOR ||
                i_op_code == ESX_OP_XOR_TO_MEMORY)) |=> $stable(o_zero_flag))
    else $error("flag changed by other op");

  skip_taken_c: cover property (issue && skip_cond ##1 o_dummy ##1 !o_busy);
  table_read_c: cover property (issue && is_preinc_op(i_op_code) ##1 o_pm_rd ##1 o_mem_we);
  xor_zero_c:   cover property (issue && i_op_code == ESX_OP_XOR_TO_MEMORY ##1 o_zero_flag);

endmodule : esx_exec

`default_nettype wire

// ===== esx_mem_model.sv
// Behavioural program flash and one data memory byte for the execution block
`timescale 1ns/100ps
`default_nettype none
module esx_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_pm_rd,
  input  wire logic [11:0] i_pm_addr,
  input  wire logic        i_mem_we,
  input  wire logic [7:0]  i_mem_wdata,
  input  wire logic        i_tb_we,
  input  wire logic [7:0]  i_tb_wdata,
  output logic      [15:0] o_pm_rdata,
  output logic      [7:0]  o_mem_rdata
);
  logic [15:0] word;
  logic [15:0] last_reg = 16'h0000;
  logic [7:0]  data_reg = 8'h00;
  // Distinct high and low bytes per address
  assign word = {i_pm_addr[11:4] + 8'h11, i_pm_addr[7:0] ^ 8'h5A};
  // Word valid only in the read cycle, inverted otherwise
  assign o_pm_rdata = i_pm_rd ? word : ~last_reg;
  always @(posedge i_clk_sys) begin
    if (i_pm_rd) last_reg <= word;
  end
  always @(posedge i_clk_sys) begin
    if (i_tb_we) data_reg <= i_tb_wdata;
    else if (i_mem_we) data_reg <= i_mem_wdata;
  end
  assign o_mem_rdata = data_reg;
endmodule : esx_mem_model
`default_nettype wire

// ===== esx_exec_tb.sv
// Self-checking bench for the skip, table read and XOR execution block
`timescale 1ns/100ps
`default_nettype none
module esx_exec_tb;
  import esx_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, lwe = 1'b0, hwe = 1'b0, awe = 1'b0, twe = 1'b0;
  esx_op_t     op = ESX_OP_NONE;
  logic [2:0]  bsel = 3'h0;
  logic [7:0]  lwd = 8'h00, awd = 8'h00, twd = 8'h00, mwd, acc, plo, lat, mrd;
  logic [3:0]  hwd = 4'h0, pg = 4'h0, phi;
  logic [11:0] pma;
  logic [15:0] pmd;
  logic        busy, dummy, skip, pmrd, mwe, zf;
  int          mismatches = 0, n_compared = 0, cyc = 0;
  int          m_acc, m_zf, m_lo, m_hi, m_lat;
  int          exp_q[$];
  esx_exec u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_op_valid(vld), .i_op_code(op),
    .i_bit_sel(bsel), .i_mem_rdata(mrd), .i_pc_page(pg), .i_ptr_low_we(lwe),
    .i_ptr_low_wdata(lwd), .i_ptr_high_we(hwe), .i_ptr_high_wdata(hwd), .i_acc_we(awe),
    .i_acc_wdata(awd), .i_pm_rdata(pmd), .o_busy(busy), .o_dummy(dummy), .o_skip(skip),
    .o_pm_rd(pmrd), .o_pm_addr(pma), .o_mem_we(mwe), .o_mem_wdata(mwd), .o_accumulator(acc),
    .o_zero_flag(zf), .o_table_pointer_low(plo), .o_table_pointer_high(phi),
    .o_table_high_byte_latch(lat));
  esx_mem_model u_mem (.i_clk_sys(clk), .i_pm_rd(pmrd), .i_pm_addr(pma), .i_mem_we(mwe),
    .i_mem_wdata(mwd), .i_tb_we(twe), .i_tb_wdata(twd), .o_pm_rdata(pmd), .o_mem_rdata(mrd));
  initial begin
    forever #25 clk = ~clk;
  end
  // ****************
  // Checks and close
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ****************
  // One instruction
  // ****************
  task run(input esx_op_t o);
    int d, a, r, w;
    logic tk, tb;
    @(negedge clk);
    d = ($urandom % 4 == 0) ? 0 : $urandom % 256;
    awd = 8'($urandom);
    lwd = 8'($urandom);
    hwd = 4'($urandom);
    pg = 4'($urandom);
    bsel = 3'($urandom);
    twd = 8'(d);
    awe = 1;
    lwe = 1;
    hwe = 1;
    twe = 1;
    m_acc = awd;
    m_lo = lwd;
    m_hi = hwd;
    @(negedge clk);
    awe = 0;
    lwe = 0;
    hwe = 0;
    twe = 0;
    vld = 1;
    op = o;
    tk = (o == ESX_OP_SKIP_ZERO_MOVE_TO_ACC && d == 0) ||
         (o == ESX_OP_SKIP_BIT_ZERO && ((d >> bsel) & 1) == 0);
    tb = o inside {[ESX_OP_TABLE_READ_CURRENT_PAGE : ESX_OP_PREINC_TABLE_READ_LAST_PAGE]};
    if (o == ESX_OP_SKIP_ZERO_MOVE_TO_ACC) m_acc = d;
    if (o inside {ESX_OP_PREINC_TABLE_READ, ESX_OP_PREINC_TABLE_READ_LAST_PAGE}) begin
      m_lo = (m_lo + 1) % 256;
    end
    a = (o == ESX_OP_TABLE_READ_CURRENT_PAGE) ? pg * 256 + m_lo :
        (o == ESX_OP_PREINC_TABLE_READ) ? m_hi * 256 + m_lo : 3840 + m_lo;
    w = ((((a >> 4) + 17) % 256) << 8) | ((a % 256) ^ 90);
    if (tb) exp_q.push_back(w);
    r = m_acc ^ d;
    if (o == ESX_OP_XOR_TO_ACCUMULATOR) m_acc = r;
    if (o inside {ESX_OP_XOR_TO_ACCUMULATOR, ESX_OP_XOR_TO_MEMORY}) m_zf = (r == 0);
    @(negedge clk);
    chk(skip, tk);
    chk({dummy, busy}, {tk, tk || tb});
    chk({pmrd, mwe}, {tb, o == ESX_OP_XOR_TO_MEMORY});
    chk(acc, m_acc);
    chk(zf, m_zf);
    chk(plo, m_lo);
    if (o == ESX_OP_XOR_TO_MEMORY) chk(mwd, r);
    if (tb) chk(pma, a);
    // Op offered while busy must be ignored
    vld = tk || tb;
    op = ESX_OP_XOR_TO_ACCUMULATOR;
    if (tb) begin
      @(negedge clk);
      w = exp_q.pop_front();
      m_lat = w >> 8;
      chk({mwe, mwd}, {1'b1, 8'(w % 256)});
      chk(lat, m_lat);
    end
    else if (tk) @(negedge clk);
    vld = 0;
    chk({busy, acc, zf}, {1'b0, 8'(m_acc), 1'(m_zf)});
  endtask : run
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(92));
    m_zf = 0;
    m_lat = 0;
    repeat (16) @(negedge clk);
    rst_b = 1;
    chk({acc, zf, lat, plo, phi}, 29'h0);
    for (int i = 0; i <= 8; i++) run(esx_op_t'(i));
    repeat (300) run(esx_op_t'($urandom % 9));
    end_of_test();
  end
endmodule : esx_exec_tb
`default_nettype wire
